// file: design/shift_lane.sv
// one bit plane of the store: a recirculating shift register
`timescale 1ns/1ps
`default_nettype none

module shift_lane #(
	parameter int unsigned LEN = 513
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic shift,
	input wire logic write,
	input wire logic write_bit,
	output logic tap
);

	logic [LEN-1:0] stages_q;
	logic entry_bit;

	// the last stage feeds back unless a new sample replaces it
	assign entry_bit = write ? write_bit : stages_q[LEN-1];
	assign tap = stages_q[LEN-1];

	// shift one stage per slot of the shift clock
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			stages_q <= '0;
		end else if (shift) begin
			stages_q <= {stages_q[LEN-2:0], entry_bit};
		end
	end

endmodule

`default_nettype wire

// file: design/store_pkg.sv
// constants shared by the recirculating trace store
package store_pkg;

	// clocking
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned SHIFT_MHZ_X10 = 25; // shift clock, 2.5 MHz
	localparam int unsigned SHIFT_HZ = SHIFT_MHZ_X10 * 100_000;
	localparam int unsigned SHIFT_DIV = CLK_HZ / SHIFT_HZ;
	localparam int unsigned SHIFT_HIGH = SHIFT_DIV / 2;
	localparam int unsigned DIV_W = $clog2(SHIFT_DIV);

	// store geometry
	localparam int unsigned STORE_LEN = 513;
	localparam int unsigned WORD_W = 8;
	localparam int unsigned LEVELS = 256;
	localparam int unsigned POS_W = $clog2(STORE_LEN);

	// interleaved read-in and readout spacing, in shift slots
	localparam int unsigned READIN_STEP = 64;
	localparam int unsigned READOUT_STEP = 128;
	localparam int unsigned IN_GAP_W = $clog2(READIN_STEP);
	localparam int unsigned OUT_GAP_W = $clog2(READOUT_STEP);
	localparam int unsigned WRITES_W = $clog2(STORE_LEN + 1);

	// readout interval: clock cycles per amplitude level
	localparam int unsigned LEVEL_CYCLES = 16;
	localparam int unsigned SUB_W = $clog2(LEVEL_CYCLES);
	localparam int unsigned GRAT_W = 5; // amplitude graticule every 32 levels

	// read-in sequencer states
	typedef enum logic [3:0] {
		SEQ_IDLE  = 4'h1,
		SEQ_ARMED = 4'h2,
		SEQ_FILL  = 4'h4,
		SEQ_FULL  = 4'h8
	} seq_state_t;

endpackage

// file: design/trace_store.sv
// digital trace store: recirculating bank, read-in sequencer and readout
`timescale 1ns/1ps
`default_nettype none

module trace_store
	import store_pkg::*;
#(
	parameter int unsigned LANES = WORD_W,
	parameter int unsigned LEN = STORE_LEN
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic start,
	input wire logic [LANES-1:0] sample,
	input wire logic [GRAT_W-1:0] amp_grat_offset,
	input wire logic [IN_GAP_W-1:0] horiz_grat_offset,
	output logic shift_clock,
	output logic wrap_pulse,
	output logic convert_strobe,
	output logic ramp_step,
	output logic store_full,
	output logic line_start,
	output logic [POS_W-1:0] line_point,
	output logic unblank,
	output logic graticule
);

	// ----------------------------------------------------------------
	// shift clock and position counter
	// ----------------------------------------------------------------

	logic [DIV_W-1:0] div_q;
	logic [DIV_W-1:0] div_d;
	logic tick;
	logic shift_clock_d;
	logic [POS_W-1:0] pos_q;
	logic [POS_W-1:0] pos_d;
	logic pos_last;
	logic wrap_pulse_q;

	// divide the system clock down to the shifting rate
	assign tick = (div_q == DIV_W'(SHIFT_DIV - 1));
	assign div_d = tick ? '0 : div_q + 1'b1;
	assign shift_clock_d = (div_d < DIV_W'(SHIFT_HIGH));

	// slot position modulo the store length
	assign pos_last = (pos_q == POS_W'(LEN - 1));
	assign pos_d = !tick ? pos_q : (pos_last ? '0 : pos_q + 1'b1);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			div_q <= '0;
			pos_q <= '0;
			shift_clock <= 1'b1;
			wrap_pulse_q <= 1'b0;
		end else begin
			div_q <= div_d;
			pos_q <= pos_d;
			shift_clock <= shift_clock_d;
			wrap_pulse_q <= tick && pos_last;
		end
	end

	assign wrap_pulse = wrap_pulse_q;

	// ----------------------------------------------------------------
	// read-in sequencer
	// ----------------------------------------------------------------

	seq_state_t state_q;
	seq_state_t state_d;
	logic [IN_GAP_W-1:0] in_gap_q;
	logic [WRITES_W-1:0] writes_q;
	logic write_slot;
	logic last_write;

	// a write every 64 slots while filling; the gap counter wraps freely
	assign write_slot = (state_q == SEQ_FILL) && tick
		&& (in_gap_q == '0);
	// 64 and 513 share no factor, so 513 writes cover every location
	assign last_write = write_slot
		&& (writes_q == WRITES_W'(LEN - 1));

	// next state: start arms, the wrap slot starts filling in step
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			SEQ_IDLE: begin
				if (start) begin
					state_d = SEQ_ARMED;
				end
			end
			SEQ_ARMED: begin
				if (tick && pos_last) begin
					state_d = SEQ_FILL;
				end
			end
			SEQ_FILL: begin
				if (last_write) begin
					state_d = SEQ_FULL;
				end
			end
			SEQ_FULL: begin
				if (start) begin
					state_d = SEQ_ARMED;
				end
			end
			default: begin
				state_d = SEQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= SEQ_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// insertion spacing and write count
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			in_gap_q <= '0;
			writes_q <= '0;
		end else if (state_q != SEQ_FILL) begin
			in_gap_q <= '0;
			writes_q <= '0;
		end else if (tick) begin
			in_gap_q <= in_gap_q + 1'b1;
			if (write_slot) begin
				writes_q <= writes_q + 1'b1;
			end
		end
	end

	// conversion command, one cycle after the write slot
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			convert_strobe <= 1'b0;
		end else begin
			convert_strobe <= write_slot;
		end
	end

	// ramp step leaves together with the conversion command
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ramp_step <= 1'b0;
		end else begin
			ramp_step <= write_slot;
		end
	end

	// full flag follows the sequencer into its full state
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			store_full <= 1'b0;
		end else begin
			store_full <= (state_d == SEQ_FULL);
		end
	end

	// ----------------------------------------------------------------
	// storage bank
	// ----------------------------------------------------------------

	logic [LANES-1:0] tap_word;

	// one lane per bit of the amplitude word
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			shift_lane #(
				.LEN(LEN)
			) u_lane (
				.clock(clock),
				.reset_n(reset_n),
				.shift(tick),
				.write(write_slot),
				.write_bit(sample[g]),
				.tap(tap_word[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// readout: interval generator and graticules
	// ----------------------------------------------------------------

	logic [OUT_GAP_W-1:0] out_gap_q;
	logic extract;
	logic [LANES-1:0] shown_q;
	logic [POS_W-1:0] point_q;
	logic active_q;
	logic [LANES-1:0] level_q;
	logic [SUB_W-1:0] sub_q;
	logic sub_end;
	logic line_end;
	logic amp_hit;
	logic horiz_hit;

	// extract the leaving word every 128 slots
	assign extract = tick && (out_gap_q == '0);
	assign sub_end = (sub_q == SUB_W'(LEVEL_CYCLES - 1));
	assign line_end = sub_end && (level_q == LANES'(LEVELS - 1));
	assign amp_hit = (level_q[GRAT_W-1:0] == amp_grat_offset);
	assign horiz_hit = (point_q[IN_GAP_W-1:0] == horiz_grat_offset);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			out_gap_q <= '0;
		end else if (tick) begin
			out_gap_q <= out_gap_q + 1'b1;
		end
	end

	// capture the word and sweep one vertical line across all levels
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			shown_q <= '0;
			point_q <= '0;
			active_q <= 1'b0;
			level_q <= '0;
			sub_q <= '0;
		end else if (extract) begin
			shown_q <= tap_word;
			point_q <= pos_q;
			active_q <= 1'b1;
			level_q <= '0;
			sub_q <= '0;
		end else if (active_q) begin
			sub_q <= sub_q + 1'b1;
			if (sub_end) begin
				level_q <= level_q + 1'b1;
			end
			if (line_end) begin
				active_q <= 1'b0;
			end
		end
	end

	// display outputs, each straight from a flip-flop
	// line marker: one cycle per extraction
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			line_start <= 1'b0;
		end else begin
			line_start <= extract;
		end
	end

	// point of the line, held until the next extraction
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			line_point <= '0;
		end else begin
			line_point <= extract ? pos_q : line_point;
		end
	end

	// unblank while the swept level is below the stored word
	// the line is dark in the cycle of the marker itself
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			unblank <= 1'b0;
		end else begin
			unblank <= active_q && (level_q < shown_q);
		end
	end

	// graticule marks inside the line window only
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			graticule <= 1'b0;
		end else begin
			graticule <= active_q && (amp_hit || horiz_hit);
		end
	end

endmodule

`default_nettype wire

// file: tb/digitiser_model.sv
// converter model: offers a new sample after each conversion
`timescale 1ns/1ps
`default_nettype none
module digitiser_model
	import store_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic convert_strobe,
	output logic [WORD_W-1:0] sample
);
	int k = 0;
	// full scale first, then zero, then random levels
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sample <= 8'hFF;
		end else if (convert_strobe) begin
			k++;
			sample <= (k == 1) ? 8'h00 : WORD_W'($urandom);
		end
	end
endmodule
`default_nettype wire

// file: tb/trace_store_chk.sv
// port assertions for the trace store
`timescale 1ns/1ps
`default_nettype none
module trace_store_chk
	import store_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic shift_clock,
	input wire logic wrap_pulse,
	input wire logic convert_strobe,
	input wire logic ramp_step,
	input wire logic line_start,
	input wire logic [POS_W-1:0] line_point,
	input wire logic unblank
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	wire [2:0] ev = {line_start, convert_strobe, wrap_pulse};
	logic [15:0] gap_q [3];
	logic [2:0] seen_q;
	// cycles since each pulse, and whether one has been seen
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			gap_q <= '{default: '0};
			seen_q <= '0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				gap_q[i] <= ev[i] ? 16'h0001 : gap_q[i] + 16'h0001;
				seen_q[i] <= seen_q[i] | ev[i];
			end
		end
	end
	chk_shift_high: assert property (
		$rose(shift_clock) |-> ##19 shift_clock ##1 !shift_clock)
		else $error("shift clock high time wrong");
	chk_shift_period: assert property (
		$rose(shift_clock) |-> ##40 $rose(shift_clock))
		else $error("shift clock period wrong");
	chk_wrap_gap: assert property (
		wrap_pulse && seen_q[0] |-> gap_q[0] == 16'h5028)
		else $error("wrap pulse spacing wrong");
	chk_write_gap: assert property (
		convert_strobe && seen_q[1] |-> gap_q[1] == 16'h0A00)
		else $error("write spacing wrong");
	chk_line_gap: assert property (
		line_start && seen_q[2] |-> gap_q[2] == 16'h1400)
		else $error("extraction spacing wrong");
	chk_ramp_pair: assert property (ramp_step == convert_strobe)
		else $error("ramp step differs from conversion");
	chk_strobe_single: assert property (
		convert_strobe |=> !convert_strobe)
		else $error("conversion strobe longer than one cycle");
	chk_unblank_src: assert property (
		$rose(unblank) |-> $past(line_start))
		else $error("unblank not started by a line");
	chk_line_dark: assert property (
		line_start |-> !unblank)
		else $error("unblank runs into next line");
	chk_point_hold: assert property (
		!line_start |-> $stable(line_point))
		else $error("line point moved without a line");
endmodule
bind trace_store trace_store_chk u_chk (.clock(clock), .reset_n(reset_n),
	.shift_clock(shift_clock), .wrap_pulse(wrap_pulse),
	.convert_strobe(convert_strobe), .ramp_step(ramp_step),
	.line_start(line_start), .line_point(line_point), .unblank(unblank));
`default_nettype wire

// file: tb/trace_store_tb.sv
// self-checking bench for the trace store
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
	bad_count++; $display("Error t=%0t got %h exp %h", $time, a, b); end end
module trace_store_tb
	import store_pkg::*;
;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic start = 1'b0;
	logic [GRAT_W-1:0] amp_off = '0;
	logic [IN_GAP_W-1:0] hor_off = '0;
	wire logic [WORD_W-1:0] sample;
	wire logic shift_clock, wrap_pulse, convert_strobe, ramp_step;
	wire logic store_full, line_start, unblank, graticule;
	wire logic [POS_W-1:0] line_point;
	int bad_count = 0;
	int comparisons = 0;
	int writes = 0;
	int ub = 0;
	int gr = 0;
	bit seen = 0;
	logic [WORD_W-1:0] mem [STORE_LEN] = '{default: '0};
	logic [POS_W-1:0] last_pt;
	always #5 clock = ~clock;
	trace_store u_dut (.clock(clock), .reset_n(reset_n), .start(start),
		.sample(sample), .amp_grat_offset(amp_off),
		.horiz_grat_offset(hor_off), .shift_clock(shift_clock),
		.wrap_pulse(wrap_pulse), .convert_strobe(convert_strobe),
		.ramp_step(ramp_step), .store_full(store_full),
		.line_start(line_start), .line_point(line_point),
		.unblank(unblank), .graticule(graticule));
	digitiser_model u_adc (.clock(clock), .reset_n(reset_n),
		.convert_strobe(convert_strobe), .sample(sample));
	// graticule cycles expected in one line window
	function automatic int exp_grat(input logic [POS_W-1:0] p);
		return (p[5:0] == hor_off) ? 4096 : 8 * LEVEL_CYCLES;
	endfunction
	// reference store and per-line interval checks
	always @(posedge clock) begin
		if (reset_n && convert_strobe) begin
			mem[(READIN_STEP * writes) % STORE_LEN] = sample;
			writes++;
		end
		if (reset_n && line_start) begin
			if (seen) begin
				`CHK(ub, LEVEL_CYCLES * mem[last_pt])
				`CHK(gr, exp_grat(last_pt))
				`CHK(line_point, POS_W'((last_pt + 128) % 513))
			end
			seen = 1;
			last_pt = line_point;
			ub = 0;
			gr = 0;
		end
		ub += (unblank === 1'b1);
		gr += (graticule === 1'b1);
	end
	task automatic end_of_test();
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// bounded wait for the next conversion strobe
	task automatic wait_strobe(input int lim);
		int n;
		n = 0;
		while (convert_strobe !== 1'b1 && n < lim) begin
			@(posedge clock);
			n++;
		end
		if (n >= lim) begin
			bad_count++;
			end_of_test();
		end
		@(posedge clock);
	endtask
	initial begin
		void'($urandom(27));
		repeat (20) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		// arm one fill with random graticule phases
		amp_off <= GRAT_W'($urandom);
		hor_off <= IN_GAP_W'($urandom);
		start <= 1'b1;
		@(posedge clock);
		start <= 1'b0;
		wait_strobe(21000);
		$display("test arm done");
		// writes keep their spacing; start held mid-fill is ignored
		for (int i = 0; i < 28; i++) begin
			start <= (i == 3);
			wait_strobe(2600);
		end
		repeat (2) @(posedge clock);
		`CHK(writes, 29)
		`CHK(store_full, 1'b0)
		$display("test fill done");
		end_of_test();
	end
endmodule
`default_nettype wire
